// [logic/retimer_adapt_params.svh]
// Purpose: offsets, field positions, reset values and timing counts for the
//          adaptation control register slice
// Assumes: 8-bit registers on the configuration port, 25 MHz reference clock
// Notes:   definitions only
`ifndef RETIMER_ADAPT_PARAMS_SVH
`define RETIMER_ADAPT_PARAMS_SVH

// =====================================================================
// register offsets
`define OFF_LOCK_QUAL      8'h2F
`define OFF_PRBS_CDR       8'h30
`define OFF_ADAPT_MODE     8'h31
`define OFF_EYE_INT_THR    8'h32
`define OFF_HANDOFF_THR    8'h33
`define OFF_LOCK_TAP       8'h34

// =====================================================================
// reset values
`define RST_LOCK_QUAL      8'h66
`define RST_PRBS_CDR       8'h00
`define RST_ADAPT_MODE     8'h40
`define RST_EYE_INT_THR    8'h11
`define RST_HANDOFF_THR    8'h88
`define RST_LOCK_TAP       8'h3F
`define RST_READ_DATA      8'h00

// =====================================================================
// field positions
`define FREQ_CHK_BIT       1
`define ADAPT_BUSY_BIT     0
`define CDR_FLAG_BIT       4
`define PRBS_CLK_BIT       3
`define PRBS_PAT_MSB       1
`define PRBS_PAT_LSB       0
`define MODE_MSB           6
`define MODE_LSB           5
`define FOM_MSB            4
`define FOM_LSB            3
`define HI_NIB_MSB         7
`define HI_NIB_LSB         4
`define LO_NIB_MSB         3
`define LO_NIB_LSB         0
`define PPM_RDY_BIT        7
`define LOW_PWR_BIT        6
`define LOCK_CNT_MSB       5
`define LOCK_CNT_LSB       4

// =====================================================================
// encodings
`define MODE_NONE          2'h0
`define MODE_LE_ONLY       2'h1
`define MODE_LE_FE_LE      2'h2
`define MODE_LOCK_FE_LE    2'h3
`define FOM_HORIZ          2'h1
`define FOM_VERT           2'h2

// =====================================================================
// timing: one monitor interval step
`define MON_STEP_NS        1000
`define CLK_PERIOD_NS      40
`define MON_STEP_CYCLES    ((`MON_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [logic/retimer_adapt_pkg.sv]
// Purpose: types shared by the adaptation control register slice
// Assumes: constants come from retimer_adapt_params.svh
// Notes:   one packed struct holds all state of the main module
package retimer_adapt_pkg;

    // =================================================================
    // adaptation sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LE_LOCK,
        ST_LE_OPT,
        ST_FE,
        ST_LE_FINAL,
        ST_DONE
    } adapt_state_t;

    // =================================================================
    // complete state of the slice
    typedef struct packed {
        adapt_state_t st;
        logic         freq_chk;
        logic         prbs_clk;
        logic [1:0]   prbs_pat;
        logic         cdr_flag;
        logic [1:0]   mode;
        logic [1:0]   fom;
        logic [3:0]   int_h;
        logic [3:0]   int_v;
        logic [3:0]   ho_h;
        logic [3:0]   ho_v;
        logic         low_pwr;
        logic [1:0]   lock_cnt;
        logic [3:0]   tap_lim;
        logic [15:0]  mon_cnt;
        logic [7:0]   rdata;
        logic         locked;
        logic         eye_low;
        logic         mon_pulse;
    } ctl_state_t;

    // threshold scaling: quad selects x4, else x2
    function automatic logic [7:0] eye_scale(input logic [3:0] thr, input logic quad);
        eye_scale = quad ? {2'h0, thr, 2'h0} : {3'h0, thr, 1'h0};
    endfunction

endpackage

// [logic/eye_compare.sv]
// Purpose: eye-opening threshold comparisons for interrupt and handoff
// Assumes: openings are same-clock values from the eye monitor
// Notes:   purely combinational
`timescale 1ns/1ns
`include "retimer_adapt_params.svh"
module eye_compare (
    input  wire logic [7:0] h_eye_open_i,
    input  wire logic [7:0] v_eye_open_i,
    input  wire logic [1:0] fom_i,
    input  wire logic [3:0] int_h_thr_i,
    input  wire logic [3:0] int_v_thr_i,
    input  wire logic [3:0] ho_h_thr_i,
    input  wire logic [3:0] ho_v_thr_i,
    output logic            eye_low_o,
    output logic            handoff_ok_o
);
    logic h_low;
    logic v_low;
    logic h_open;
    logic v_open;

    // =================================================================
    // comparisons
    always_comb begin
        h_low  = h_eye_open_i < retimer_adapt_pkg::eye_scale(int_h_thr_i, 1'b1);
        v_low  = v_eye_open_i < retimer_adapt_pkg::eye_scale(int_v_thr_i, 1'b1);
        h_open = h_eye_open_i >= retimer_adapt_pkg::eye_scale(ho_h_thr_i, 1'b0);
        // vertical handoff judged on vertical opening
        v_open = v_eye_open_i >= retimer_adapt_pkg::eye_scale(ho_v_thr_i, 1'b0);
        eye_low_o = h_low | v_low;
        case (fom_i)
            `FOM_HORIZ: handoff_ok_o = h_open;
            `FOM_VERT:  handoff_ok_o = v_open;
            default:    handoff_ok_o = h_open & v_open;
        endcase
    end
endmodule // eye_compare

// [logic/retimer_adaptation_control_regs.sv]
// Purpose: adaptation control and status registers of one retimer channel
// Assumes: all status inputs come from logic on ref_clk_i, so none is
//          synchronised; configuration port is a simple strobed port
// Notes:   one packed state struct, one comb copy, one register process
//
// Behaviour
// - the mode field selects none, linear only, linear-feedback-linear, or lock-feedback-linear.
// - the merit field makes handoff judge horizontal only, vertical only, or both openings.
// - the horizontal interrupt threshold times four is compared with the horizontal opening.
// - the vertical interrupt threshold times four is compared with the vertical opening.
// - the horizontal handoff threshold times two, like the linear optimum, can trigger the move to feedback adaptation.
// - the vertical handoff threshold times two can also trigger the move to feedback adaptation.
// - a read-only flag goes high whenever the recovery interrupt asserts, reset low.
// - one bit enables the pattern generator clock and two bits choose its pattern.
// - when set, lock also requires the frequency lock detector, default set.
// - a four-bit field caps the magnitude of feedback taps two to five.
// - with monitoring on, after lock and adaptation the eye is rechecked each interval.
`timescale 1ns/1ns
`include "retimer_adapt_params.svh"
module retimer_adaptation_control_regs (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    input  wire logic [7:0] cfg_addr_i,
    input  wire logic [7:0] cfg_wdata_i,
    input  wire logic       cfg_wr_i,
    input  wire logic       cfg_rd_i,
    output logic      [7:0] cfg_rdata_o,
    input  wire logic       start_adapt_i,
    input  wire logic       le_optimal_i,
    input  wire logic       fe_done_i,
    input  wire logic       cdr_lock_i,
    input  wire logic       freq_lock_i,
    input  wire logic       cdr_irq_i,
    input  wire logic       ppm_ready_i,
    input  wire logic [7:0] h_eye_open_i,
    input  wire logic [7:0] v_eye_open_i,
    input  wire logic       monitor_en_i,
    input  wire logic [3:0] monitor_interval_i,
    output logic      [1:0] fom_select_o,
    output logic            adapt_le_o,
    output logic            adapt_fe_o,
    output logic            adapt_done_o,
    output logic            cdr_locked_o,
    output logic            cdr_flag_o,
    output logic            eye_low_o,
    output logic            monitor_pulse_o,
    output logic            prbs_clk_en_o,
    output logic      [1:0] prbs_pattern_o,
    output logic      [3:0] fe_tap_limit_o,
    output logic            low_power_dis_o,
    output logic      [1:0] lock_count_o
);
    localparam logic [15:0] MON_STEP = 16'(`MON_STEP_CYCLES);
    // named copies so that reset fields can be bit-selected
    localparam logic [7:0]  RST_LQ   = `RST_LOCK_QUAL;
    localparam logic [7:0]  RST_PC   = `RST_PRBS_CDR;
    localparam logic [7:0]  RST_AM   = `RST_ADAPT_MODE;
    localparam logic [7:0]  RST_EI   = `RST_EYE_INT_THR;
    localparam logic [7:0]  RST_HO   = `RST_HANDOFF_THR;
    localparam logic [7:0]  RST_LT   = `RST_LOCK_TAP;

    localparam retimer_adapt_pkg::ctl_state_t RST_STATE = '{
        st:        retimer_adapt_pkg::ST_IDLE,
        freq_chk:  RST_LQ[`FREQ_CHK_BIT],
        prbs_clk:  RST_PC[`PRBS_CLK_BIT],
        prbs_pat:  RST_PC[`PRBS_PAT_MSB:`PRBS_PAT_LSB],
        cdr_flag:  RST_PC[`CDR_FLAG_BIT],
        mode:      RST_AM[`MODE_MSB:`MODE_LSB],
        fom:       RST_AM[`FOM_MSB:`FOM_LSB],
        int_h:     RST_EI[`HI_NIB_MSB:`HI_NIB_LSB],
        int_v:     RST_EI[`LO_NIB_MSB:`LO_NIB_LSB],
        ho_h:      RST_HO[`HI_NIB_MSB:`HI_NIB_LSB],
        ho_v:      RST_HO[`LO_NIB_MSB:`LO_NIB_LSB],
        low_pwr:   RST_LT[`LOW_PWR_BIT],
        lock_cnt:  RST_LT[`LOCK_CNT_MSB:`LOCK_CNT_LSB],
        tap_lim:   RST_LT[`LO_NIB_MSB:`LO_NIB_LSB],
        mon_cnt:   16'h0000,
        rdata:     `RST_READ_DATA,
        locked:    1'b0,
        eye_low:   1'b0,
        mon_pulse: 1'b0
    };

    retimer_adapt_pkg::ctl_state_t state_ff;
    retimer_adapt_pkg::ctl_state_t nxt_state;
    logic                          eye_low_now;
    logic                          handoff_ok;
    logic                          qual_lock;
    logic                          busy;
    logic [15:0]                   mon_period;
    logic [7:0]                    rd_val;

    // =================================================================
    // eye comparisons
    eye_compare u_eye_compare (
        .h_eye_open_i (h_eye_open_i),
        .v_eye_open_i (v_eye_open_i),
        .fom_i        (state_ff.fom),
        .int_h_thr_i  (state_ff.int_h),
        .int_v_thr_i  (state_ff.int_v),
        .ho_h_thr_i   (state_ff.ho_h),
        .ho_v_thr_i   (state_ff.ho_v),
        .eye_low_o    (eye_low_now),
        .handoff_ok_o (handoff_ok)
    );

    // =================================================================
    // next state
    always_comb begin
        nxt_state  = state_ff;
        qual_lock  = cdr_lock_i & (~state_ff.freq_chk | freq_lock_i);
        busy       = (state_ff.st != retimer_adapt_pkg::ST_IDLE) &&
                     (state_ff.st != retimer_adapt_pkg::ST_DONE);
        mon_period = 16'({12'h000, monitor_interval_i} + 16'h0001) * MON_STEP;
        rd_val     = 8'h00;

        // read mux; reserved bits show their reset value
        unique case (cfg_addr_i)
            `OFF_LOCK_QUAL: begin
                rd_val = `RST_LOCK_QUAL;
                rd_val[`FREQ_CHK_BIT]   = state_ff.freq_chk;
                rd_val[`ADAPT_BUSY_BIT] = busy;
            end
            `OFF_PRBS_CDR: begin
                rd_val = `RST_PRBS_CDR;
                rd_val[`CDR_FLAG_BIT] = state_ff.cdr_flag;
                rd_val[`PRBS_CLK_BIT] = state_ff.prbs_clk;
                rd_val[`PRBS_PAT_MSB:`PRBS_PAT_LSB] = state_ff.prbs_pat;
            end
            `OFF_ADAPT_MODE: begin
                rd_val = `RST_ADAPT_MODE;
                rd_val[`MODE_MSB:`MODE_LSB] = state_ff.mode;
                rd_val[`FOM_MSB:`FOM_LSB]   = state_ff.fom;
            end
            `OFF_EYE_INT_THR: rd_val = {state_ff.int_h, state_ff.int_v};
            `OFF_HANDOFF_THR: rd_val = {state_ff.ho_h, state_ff.ho_v};
            `OFF_LOCK_TAP: begin
                rd_val[`PPM_RDY_BIT] = ppm_ready_i;
                rd_val[`LOW_PWR_BIT] = state_ff.low_pwr;
                rd_val[`LOCK_CNT_MSB:`LOCK_CNT_LSB] = state_ff.lock_cnt;
                rd_val[`LO_NIB_MSB:`LO_NIB_LSB]     = state_ff.tap_lim;
            end
            default: rd_val = 8'h00;
        endcase
        if (cfg_rd_i) begin
            nxt_state.rdata = rd_val;
        end

        // writes touch only writable fields
        if (cfg_wr_i) begin
            unique case (cfg_addr_i)
                `OFF_LOCK_QUAL: nxt_state.freq_chk = cfg_wdata_i[`FREQ_CHK_BIT];
                `OFF_PRBS_CDR: begin
                    nxt_state.prbs_clk = cfg_wdata_i[`PRBS_CLK_BIT];
                    nxt_state.prbs_pat = cfg_wdata_i[`PRBS_PAT_MSB:`PRBS_PAT_LSB];
                end
                `OFF_ADAPT_MODE: begin
                    nxt_state.mode = cfg_wdata_i[`MODE_MSB:`MODE_LSB];
                    nxt_state.fom  = cfg_wdata_i[`FOM_MSB:`FOM_LSB];
                end
                `OFF_EYE_INT_THR: begin
                    nxt_state.int_h = cfg_wdata_i[`HI_NIB_MSB:`HI_NIB_LSB];
                    nxt_state.int_v = cfg_wdata_i[`LO_NIB_MSB:`LO_NIB_LSB];
                end
                `OFF_HANDOFF_THR: begin
                    nxt_state.ho_h = cfg_wdata_i[`HI_NIB_MSB:`HI_NIB_LSB];
                    nxt_state.ho_v = cfg_wdata_i[`LO_NIB_MSB:`LO_NIB_LSB];
                end
                `OFF_LOCK_TAP: begin
                    nxt_state.low_pwr  = cfg_wdata_i[`LOW_PWR_BIT];
                    nxt_state.lock_cnt = cfg_wdata_i[`LOCK_CNT_MSB:`LOCK_CNT_LSB];
                    nxt_state.tap_lim  = cfg_wdata_i[`LO_NIB_MSB:`LO_NIB_LSB];
                end
                default: ;
            endcase
        end

        // read clears the flag, but a new interrupt wins over the clear
        if (cfg_rd_i && cfg_addr_i == `OFF_PRBS_CDR) begin
            nxt_state.cdr_flag = 1'b0;
        end
        if (cdr_irq_i) begin
            nxt_state.cdr_flag = 1'b1;
        end

        nxt_state.locked    = qual_lock;
        nxt_state.eye_low   = eye_low_now;
        nxt_state.mon_pulse = 1'b0;

        // adaptation sequencer
        unique case (state_ff.st)
            retimer_adapt_pkg::ST_IDLE: begin
                if (start_adapt_i) begin
                    unique case (state_ff.mode)
                        `MODE_NONE:       nxt_state.st = retimer_adapt_pkg::ST_IDLE;
                        `MODE_LOCK_FE_LE: nxt_state.st = retimer_adapt_pkg::ST_LE_LOCK;
                        default:          nxt_state.st = retimer_adapt_pkg::ST_LE_OPT;
                    endcase
                end
            end
            retimer_adapt_pkg::ST_LE_LOCK: begin
                if (qual_lock) begin
                    nxt_state.st = retimer_adapt_pkg::ST_FE;
                end
            end
            retimer_adapt_pkg::ST_LE_OPT: begin
                if (state_ff.mode == `MODE_LE_ONLY && le_optimal_i) begin
                    nxt_state.st = retimer_adapt_pkg::ST_DONE;
                end else if (state_ff.mode != `MODE_LE_ONLY &&
                             (le_optimal_i || handoff_ok)) begin
                    nxt_state.st = retimer_adapt_pkg::ST_FE;
                end
            end
            retimer_adapt_pkg::ST_FE: begin
                if (fe_done_i) begin
                    nxt_state.st = retimer_adapt_pkg::ST_LE_FINAL;
                end
            end
            retimer_adapt_pkg::ST_LE_FINAL: begin
                if (le_optimal_i) begin
                    nxt_state.st = retimer_adapt_pkg::ST_DONE;
                end
            end
            retimer_adapt_pkg::ST_DONE: begin
                // periodic eye recheck once locked and adapted
                if (!qual_lock) begin
                    nxt_state.st      = retimer_adapt_pkg::ST_IDLE;
                    nxt_state.mon_cnt = 16'h0000;
                end else if (monitor_en_i) begin
                    if (state_ff.mon_cnt + 16'h0001 >= mon_period) begin
                        nxt_state.mon_cnt   = 16'h0000;
                        nxt_state.mon_pulse = 1'b1;
                    end else begin
                        nxt_state.mon_cnt = state_ff.mon_cnt + 16'h0001;
                    end
                end else begin
                    nxt_state.mon_cnt = 16'h0000;
                end
            end
            default: nxt_state.st = retimer_adapt_pkg::ST_IDLE;
        endcase
    end

    // =================================================================
    // state register; ce low freezes everything
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= RST_STATE;
        end else if (ce_i) begin
            state_ff <= nxt_state;
        end
    end

    // =================================================================
    // outputs
    assign cfg_rdata_o     = state_ff.rdata;
    assign fom_select_o    = state_ff.fom;
    assign adapt_le_o      = (state_ff.st == retimer_adapt_pkg::ST_LE_LOCK) ||
                             (state_ff.st == retimer_adapt_pkg::ST_LE_OPT) ||
                             (state_ff.st == retimer_adapt_pkg::ST_LE_FINAL);
    assign adapt_fe_o      = state_ff.st == retimer_adapt_pkg::ST_FE;
    assign adapt_done_o    = state_ff.st == retimer_adapt_pkg::ST_DONE;
    assign cdr_locked_o    = state_ff.locked;
    assign cdr_flag_o      = state_ff.cdr_flag;
    assign eye_low_o       = state_ff.eye_low;
    assign monitor_pulse_o = state_ff.mon_pulse;
    assign prbs_clk_en_o   = state_ff.prbs_clk;
    assign prbs_pattern_o  = state_ff.prbs_pat;
    assign fe_tap_limit_o  = state_ff.tap_lim;
    assign low_power_dis_o = state_ff.low_pwr;
    assign lock_count_o    = state_ff.lock_cnt;

    // =================================================================
    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    sequence wr_prbs_s;
        ce_i && cfg_wr_i && cfg_addr_i == `OFF_PRBS_CDR;
    endsequence
    sequence prbs_follow_s;
        prbs_clk_en_o == $past(cfg_wdata_i[`PRBS_CLK_BIT]) &&
        prbs_pattern_o == $past(cfg_wdata_i[1:0]);
    endsequence
    sequence irq_seen_s;
        ce_i && cdr_irq_i;
    endsequence

    mode_none_idle_a: assert property (ce_i && state_ff.mode == `MODE_NONE &&
        state_ff.st == retimer_adapt_pkg::ST_IDLE |=> !adapt_le_o && !adapt_fe_o)
        else $error("adaptation started with mode none");
    le_only_done_a: assert property (ce_i &&
        state_ff.st == retimer_adapt_pkg::ST_LE_OPT && state_ff.mode == `MODE_LE_ONLY &&
        le_optimal_i |=> adapt_done_o && !adapt_fe_o)
        else $error("linear only mode did not finish");
    fom_horiz_only_a: assert property (state_ff.fom == `FOM_HORIZ &&
        h_eye_open_i >= {3'h0, state_ff.ho_h, 1'h0} |-> handoff_ok)
        else $error("horizontal handoff missed");
    h_int_thr_a: assert property (ce_i &&
        h_eye_open_i < {2'h0, state_ff.int_h, 2'h0} |=> eye_low_o)
        else $error("horizontal low opening not flagged");
    v_int_thr_a: assert property (ce_i &&
        v_eye_open_i < {2'h0, state_ff.int_v, 2'h0} |=> eye_low_o)
        else $error("vertical low opening not flagged");
    fom_vert_only_a: assert property (state_ff.fom == `FOM_VERT &&
        v_eye_open_i >= {3'h0, state_ff.ho_v, 1'h0} |-> handoff_ok)
        else $error("vertical handoff missed");
    cdr_flag_set_a: assert property (irq_seen_s |=> cdr_flag_o)
        else $error("recovery interrupt flag not set");
    prbs_write_a: assert property (wr_prbs_s |=> prbs_follow_s)
        else $error("pattern generator controls not updated");
    lock_qual_off_a: assert property (ce_i && !state_ff.freq_chk && cdr_lock_i
        |=> cdr_locked_o)
        else $error("lock not declared without detector check");
    lock_qual_on_a: assert property (ce_i && state_ff.freq_chk && !freq_lock_i
        |=> !cdr_locked_o)
        else $error("lock declared without frequency lock");
    tap_limit_wr_a: assert property (ce_i && cfg_wr_i &&
        cfg_addr_i == `OFF_LOCK_TAP |=> fe_tap_limit_o == $past(cfg_wdata_i[3:0]))
        else $error("tap limit not updated");
    monitor_gate_a: assert property (monitor_pulse_o |->
        $past(adapt_done_o) && $past(monitor_en_i))
        else $error("eye recheck outside monitoring");
    reserved_rd_a: assert property (ce_i && cfg_rd_i &&
        cfg_addr_i == `OFF_ADAPT_MODE |=> cfg_rdata_o[7] == 1'b0 && cfg_rdata_o[2:0] == 3'h0)
        else $error("reserved bits not at reset value");

endmodule // retimer_adaptation_control_regs

// [verification/tb.sv]
// Purpose: self-checking bench for the adaptation control register slice
// Assumes: reads answer one cycle after the read edge; inputs change at falling edges
// Notes:   register contents are mirrored in associative arrays keyed by offset
`timescale 1ns/1ns
`include "retimer_adapt_params.svh"
module tb;
    logic       ref_clk_i, rst_i, ce_i, cfg_wr_i, cfg_rd_i, start_adapt_i, le_optimal_i;
    logic       fe_done_i, cdr_lock_i, freq_lock_i, cdr_irq_i, ppm_ready_i, monitor_en_i;
    logic [7:0] cfg_addr_i, cfg_wdata_i, h_eye_open_i, v_eye_open_i, cfg_rdata_o, v, a;
    logic [3:0] monitor_interval_i, fe_tap_limit_o;
    logic [1:0] fom_select_o, prbs_pattern_o, lock_count_o;
    logic       adapt_le_o, adapt_fe_o, adapt_done_o, cdr_locked_o, cdr_flag_o, eye_low_o;
    logic       monitor_pulse_o, prbs_clk_en_o, low_power_dis_o, seen_fe;
    int         n_errors = 0;
    int         checks_done = 0;
    int         cycles = 0;
    int         seed = 32'h6ABD505C;
    int         mdl [int];
    int         wmask [int];
    int         cnt;

    retimer_adaptation_control_regs DUT (.ref_clk_i, .rst_i, .ce_i, .cfg_addr_i, .cfg_wdata_i,
        .cfg_wr_i, .cfg_rd_i, .cfg_rdata_o, .start_adapt_i, .le_optimal_i, .fe_done_i,
        .cdr_lock_i, .freq_lock_i, .cdr_irq_i, .ppm_ready_i, .h_eye_open_i, .v_eye_open_i,
        .monitor_en_i, .monitor_interval_i, .fom_select_o, .adapt_le_o, .adapt_fe_o,
        .adapt_done_o,
        .cdr_locked_o, .cdr_flag_o, .eye_low_o, .monitor_pulse_o, .prbs_clk_en_o,
        .prbs_pattern_o, .fe_tap_limit_o, .low_power_dis_o, .lock_count_o);

    // =====================================================================
    // clock, timeout and helpers
    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            results();
        end
    end

    task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic logic [7:0] exp_reg(int adr);
        exp_reg = mdl.exists(adr) ? mdl[adr][7:0] : 8'h00;
        if (adr == `OFF_LOCK_TAP) exp_reg[7] = ppm_ready_i;
    endfunction

    // model follows only writes that the port accepts
    task automatic wr(logic [7:0] adr, logic [7:0] d);
        @(negedge ref_clk_i);
        cfg_addr_i = adr;
        cfg_wdata_i = d;
        cfg_wr_i = 1'b1;
        @(negedge ref_clk_i);
        cfg_wr_i = 1'b0;
        if (ce_i && mdl.exists(adr)) mdl[adr] = (mdl[adr] & ~wmask[adr]) | (d & wmask[adr]);
    endtask

    task automatic rd(logic [7:0] adr);
        @(negedge ref_clk_i);
        cfg_addr_i = adr;
        cfg_rd_i = 1'b1;
        @(negedge ref_clk_i);
        cfg_rd_i = 1'b0;
        v = cfg_rdata_o;
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // =====================================================================
    // main sequence
    initial begin
        {ce_i, cfg_wr_i, cfg_rd_i, start_adapt_i, le_optimal_i, fe_done_i} = '0;
        {cdr_lock_i, freq_lock_i, cdr_irq_i, ppm_ready_i, monitor_en_i} = '0;
        {cfg_addr_i, cfg_wdata_i, h_eye_open_i, v_eye_open_i, monitor_interval_i} = '0;
        mdl = '{8'h2F: `RST_LOCK_QUAL, 8'h30: `RST_PRBS_CDR, 8'h31: `RST_ADAPT_MODE,
                8'h32: `RST_EYE_INT_THR, 8'h33: `RST_HANDOFF_THR, 8'h34: `RST_LOCK_TAP};
        wmask = '{8'h2F: 8'h02, 8'h30: 8'h0B, 8'h31: 8'h78, 8'h32: 8'hFF, 8'h33: 8'hFF,
                  8'h34: 8'h7F};
        rst_i = 1'b1;
        repeat (6) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        rst_i = 1'b0;
        ce_i = 1'b1;
        foreach (mdl[k]) begin
            rd(k[7:0]);
            check("reset value", v, exp_reg(k));
        end
        $display("test reset values done");
        // random writes, an unmapped offset and a disabled port among them
        repeat (30) begin
            a = 8'h2F + 8'(($random(seed) & 32'h7FFF) % 7);
            ce_i = ($random(seed) & 7) != 0;
            ppm_ready_i = $random(seed);
            wr(a, 8'($random(seed)));
            ce_i = 1'b1;
            rd(a);
            check("readback", v, exp_reg(a));
            check("prbs and merit", {3'h0, prbs_clk_en_o, prbs_pattern_o, fom_select_o},
                  {3'h0, mdl[8'h30][3], mdl[8'h30][1:0], mdl[8'h31][4:3]});
            check("limits", {1'b0, low_power_dis_o, lock_count_o, fe_tap_limit_o},
                  {1'b0, mdl[8'h34][6:0]});
        end
        $display("test register access done");
        @(negedge ref_clk_i);
        cdr_irq_i = 1'b1;
        @(negedge ref_clk_i);
        cdr_irq_i = 1'b0;
        check("cdr flag", {7'h0, cdr_flag_o}, 8'h01);
        rd(8'h30);
        check("flag read", v, exp_reg(8'h30) | 8'h10);
        rd(8'h30);
        check("flag cleared", v, exp_reg(8'h30));
        $display("test cdr flag done");
        wr(8'h32, 8'($random(seed)));
        repeat (24) begin
            h_eye_open_i = $random(seed) & 8'h3F;
            v_eye_open_i = $random(seed) & 8'h3F;
            @(negedge ref_clk_i);
            check("eye low", {7'h0, eye_low_o}, {7'h0, (h_eye_open_i < mdl[8'h32][7:4] * 4) ||
                  (v_eye_open_i < mdl[8'h32][3:0] * 4)});
        end
        $display("test eye threshold done");
        for (int j = 0; j < 2; j++) begin
            wr(8'h2F, 8'(j << 1));
            for (int i = 0; i < 4; i++) begin
                {cdr_lock_i, freq_lock_i} = 2'(i);
                @(negedge ref_clk_i);
                check("qualified lock", {7'h0, cdr_locked_o},
                      {7'h0, cdr_lock_i & (freq_lock_i | (j == 0))});
            end
        end
        $display("test lock qualifier done");
        {h_eye_open_i, v_eye_open_i} = '0;
        for (int m = 0; m < 4; m++) begin
            wr(8'h31, 8'(m << 5));
            {cdr_lock_i, freq_lock_i, monitor_en_i} = 3'h7;
            monitor_interval_i = $random(seed);
            @(negedge ref_clk_i);
            start_adapt_i = 1'b1;
            @(negedge ref_clk_i);
            start_adapt_i = 1'b0;
            check("linear adapting", {7'h0, adapt_le_o}, {7'h0, m != 0});
            rd(8'h2F);
            check("busy", v, exp_reg(8'h2F) | 8'(m != 0));
            // mode 11 may already sit in the feedback step here
            seen_fe = adapt_fe_o;
            {le_optimal_i, fe_done_i} = 2'h3;
            for (int k = 0; k < 20 && !adapt_done_o; k++) begin
                @(negedge ref_clk_i);
                seen_fe |= adapt_fe_o;
            end
            check("done", {7'h0, adapt_done_o}, {7'h0, m != 0});
            check("feedback step", {7'h0, seen_fe}, {7'h0, m >= 2});
            if (m != 0) begin
                cnt = 0;
                for (int k = 0; k < 500 && !monitor_pulse_o; k++) @(negedge ref_clk_i);
                @(negedge ref_clk_i);
                for (cnt = 1; cnt < 500 && !monitor_pulse_o; cnt++) @(negedge ref_clk_i);
                check("monitor interval", 8'(cnt),
                      8'((monitor_interval_i + 1) * `MON_STEP_CYCLES));
            end
            {cdr_lock_i, le_optimal_i, fe_done_i} = '0;
            repeat (3) @(negedge ref_clk_i);
            check("back to idle", {7'h0, adapt_done_o}, 8'h00);
        end
        $display("test adaptation modes done");
        results();
    end
endmodule // tb
